// File: gpg_board.sv
// board side of the two ports: each pin shows the unit's drive or the board's level
// assumes the board drives only pins whose output enable is low
`timescale 1ns/1ns
`default_nettype none

module gpg_board (
  input wire logic [31:0] out0_i,
  input wire logic [31:0] oe0_i,
  input wire logic [31:0] out1_i,
  input wire logic [31:0] oe1_i,
  input wire logic [31:0] ext0_i,
  input wire logic [31:0] ext1_i,
  output logic [31:0] port0_level_word_o,
  output logic [31:0] port1_level_word_o
);
  // a driven pin follows the unit, an undriven one the board (no contention modelled)
  assign port0_level_word_o = (out0_i & oe0_i) | (ext0_i & ~oe0_i);
  assign port1_level_word_o = (out1_i & oe1_i) | (ext1_i & ~oe1_i);
endmodule

`default_nettype wire

// File: gpg_pkg.sv
// constants for the two-port pin unit: address map, field positions, reset values
// assumes a 16-bit byte address from a plain strobe-based register port
package gpg_pkg;

  localparam int ADDR_W = 16;
  localparam int SEL_W = 6;            // selector picks one of 64 pin slots
  localparam int NUM_PIN_IRQ = 8;
  localparam int NUM_GROUPS = 2;
  localparam int PORT_W = 32;

  // access sizes on bus_size_i
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // block decode on the top address bits
  localparam logic [1:0] REGION_PORT = 2'h0;    // addr[15:14]
  localparam logic [3:0] BLK_PIN_IRQ = 4'h4;    // addr[15:12]
  localparam logic [3:0] BLK_FIRST_COMBINED_IRQ_UNIT = 4'h5;
  localparam logic [3:0] BLK_SECOND_COMBINED_IRQ_UNIT = 4'h6;

  // port block offsets
  localparam logic [15:0] OFF_BYTE_LAST = 16'h0028;  // last aligned word of byte pins
  localparam logic [7:0] OFF_WORD_PAGE = 8'h10;      // word pins live at 0x10xx
  localparam logic [15:0] OFF_PORT0_DIRECTION = 16'h2000;
  localparam logic [15:0] OFF_PORT1_DIRECTION = 16'h2004;
  localparam logic [15:0] OFF_PORT0_ACCESS_FILTER = 16'h2080;
  localparam logic [15:0] OFF_PORT1_ACCESS_FILTER = 16'h2084;
  localparam logic [15:0] OFF_PORT0_LEVEL_WORD = 16'h2100;
  localparam logic [15:0] OFF_PORT1_LEVEL_WORD = 16'h2104;
  localparam logic [15:0] OFF_PORT0_FILTERED_WORD = 16'h2180;
  localparam logic [15:0] OFF_PORT1_FILTERED_WORD = 16'h2184;
  localparam logic [15:0] OFF_PORT0_OUTPUT_ASSERT = 16'h2200;
  localparam logic [15:0] OFF_PORT1_OUTPUT_ASSERT = 16'h2204;
  localparam logic [15:0] OFF_PORT0_OUTPUT_DEASSERT = 16'h2280;
  localparam logic [15:0] OFF_PORT1_OUTPUT_DEASSERT = 16'h2284;
  localparam logic [15:0] OFF_PORT0_OUTPUT_INVERT = 16'h2300;
  localparam logic [15:0] OFF_PORT1_OUTPUT_INVERT = 16'h2304;

  // pin interrupt block offsets
  localparam logic [11:0] OFF_SENS = 12'h000;
  localparam logic [11:0] OFF_RLEN = 12'h004;
  localparam logic [11:0] OFF_RLEN_SET = 12'h008;
  localparam logic [11:0] OFF_RLEN_CLR = 12'h00C;
  localparam logic [11:0] OFF_FPEN = 12'h010;
  localparam logic [11:0] OFF_FPEN_SET = 12'h014;
  localparam logic [11:0] OFF_FPEN_CLR = 12'h018;
  localparam logic [11:0] OFF_RISE = 12'h01C;
  localparam logic [11:0] OFF_FALL = 12'h020;
  localparam logic [11:0] OFF_PEND = 12'h024;

  // grouped interrupt offsets
  localparam logic [11:0] OFF_GCTRL = 12'h000;
  localparam logic [11:0] OFF_GPOL0 = 12'h020;
  localparam logic [11:0] OFF_GPOL1 = 12'h024;
  localparam logic [11:0] OFF_GENA0 = 12'h040;
  localparam logic [11:0] OFF_GENA1 = 12'h044;

  // group control fields
  localparam int GCTRL_INT = 0;        // status, write one to clear
  localparam int GCTRL_COMB = 1;       // 0 = OR, 1 = AND
  localparam int GCTRL_TRIG = 2;       // 0 = edge, 1 = level

  localparam logic [31:0] GPOL_RESET = 32'hFFFFFFFF;
  localparam logic [63:0] GENA_RESET = 64'h0000000000000000;

endpackage

// File: gpg_props.sv
// port checker for the pin unit: bus answers, output and enable updates
// assumes word writes to the port-0 registers and the top module's own clock
`timescale 1ns/1ns
`default_nettype none

module gpg_props #(
  parameter int P1_PINS = 10
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [gpg_pkg::ADDR_W-1:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic [1:0] bus_size_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [31:0] bus_rdata_o,
  input wire logic [31:0] port0_out_o,
  input wire logic [31:0] port0_oe_o,
  input wire logic [31:0] port1_out_o,
  input wire logic [31:0] port1_oe_o,
  input wire logic [gpg_pkg::NUM_PIN_IRQ-1:0] pin_irq_o,
  input wire logic [gpg_pkg::NUM_GROUPS-1:0] group_irq_o
);
  import gpg_pkg::*;

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // a word write at this edge; kept as a signal so properties see its sampled value
  logic wword;
  assign wword = bus_wr_i && bus_size_i == SIZE_WORD;

  a_rdata_idle: assert property (!bus_rd_i |=> bus_rdata_o == 32'h0)
    else $error("read data not zero outside read answer");
  a_reset_quiet: assert property ($fell(sys_rst_i) |->
    (port0_oe_o | port1_oe_o | port0_out_o) == 32'h0 && pin_irq_o == '0)
    else $error("outputs not quiet after reset");
  a_dir_load: assert property (wword && bus_addr_i == OFF_PORT0_DIRECTION |=>
    port0_oe_o == $past(bus_wdata_i))
    else $error("direction write not applied");
  a_oe_hold: assert property (!(bus_wr_i && bus_addr_i == OFF_PORT0_DIRECTION) |=> $stable(port0_oe_o))
    else $error("output enable moved without direction write");
  a_set_or: assert property (wword && bus_addr_i == OFF_PORT0_OUTPUT_ASSERT |=>
    port0_out_o == ($past(port0_out_o) | $past(bus_wdata_i)))
    else $error("set write wrong");
  a_clr_and: assert property (wword && bus_addr_i == OFF_PORT0_OUTPUT_DEASSERT |=>
    port0_out_o == ($past(port0_out_o) & ~$past(bus_wdata_i)))
    else $error("clear write wrong");
  a_not_xor: assert property (wword && bus_addr_i == OFF_PORT0_OUTPUT_INVERT |=>
    port0_out_o == ($past(port0_out_o) ^ $past(bus_wdata_i)))
    else $error("toggle write wrong");
  a_set_read: assert property (bus_rd_i && bus_addr_i == OFF_PORT0_OUTPUT_ASSERT |=>
    bus_rdata_o == $past(port0_out_o))
    else $error("output bits read wrong");
  a_p1_unused: assert property (((port1_out_o | port1_oe_o) >> P1_PINS) == 32'h0)
    else $error("missing port 1 pins driven");

  c_toggle: cover property (wword && bus_addr_i == OFF_PORT0_OUTPUT_INVERT);
  c_pin_irq: cover property ($rose(pin_irq_o[0]));
  c_group_irq: cover property ($rose(group_irq_o[0]));
endmodule

bind gpg_top gpg_props #(.P1_PINS(P1_PINS)) u_props (.clk_i, .sys_rst_i, .bus_addr_i,
  .bus_wdata_i, .bus_size_i, .bus_wr_i, .bus_rd_i, .bus_rdata_o, .port0_out_o, .port0_oe_o,
  .port1_out_o, .port1_oe_o, .pin_irq_o, .group_irq_o);

`default_nettype wire

// File: gpg_top.sv
// two-port pin unit: pin access, eight selectable pin interrupts, two grouped interrupts
// assumes a same-clock register master and asynchronous board pins on the pin inputs
//
// Overview of operation
// - eight pin interrupts, each pin chosen by an external selector input.
// - sensitivity bit 0 means edge, 1 means level; resets to edge.
// - in edge mode the rise/level enable bit enables rising-edge detection.
// - in level mode that bit enables the interrupt; polarity bit picks high or low.
// - each of two groups may enable any port 0 or port 1 pin.
// - group polarity resets to all ones; enables and control reset to zero.
// - port block takes byte, halfword and word reads and writes.
// - one byte register per port 0 pin at 0x0000 to 0x001F.
// - port 1 byte registers continue at 0x0020 to 0x0029.
// - one word register per pin, 0x1000 up for port 0, 0x1080 up for port 1.
// - direction registers at 0x2000 and 0x2004, reset zero.
// - mask registers 0x2080/0x2084 reset zero and filter masked port access.
// - set register writes ones high; read returns current output bits, reset zero.
// - pin, port and masked reads return live pin states.
// - bits without a function are reserved.
// - enable setter and clearer registers set or clear bits written as one.
// - after reset all pins are inputs and pin interrupts are disabled.
`timescale 1ns/1ns
`default_nettype none

module gpg_top #(
  parameter int P1_PINS = 10
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [gpg_pkg::ADDR_W-1:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic [1:0] bus_size_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [31:0] bus_rdata_o,
  input wire logic [31:0] port0_pin_i,
  input wire logic [31:0] port1_pin_i,
  output logic [31:0] port0_out_o,
  output logic [31:0] port0_oe_o,
  output logic [31:0] port1_out_o,
  output logic [31:0] port1_oe_o,
  input wire logic [gpg_pkg::NUM_PIN_IRQ*gpg_pkg::SEL_W-1:0] irq_source_selector_i,
  output logic [gpg_pkg::NUM_PIN_IRQ-1:0] pin_irq_o,
  output logic [gpg_pkg::NUM_GROUPS-1:0] group_irq_o
);
  import gpg_pkg::*;

  if (P1_PINS < 1 || P1_PINS > PORT_W) begin : g_bad_width
    $error("P1_PINS must lie between 1 and 32");
  end

  // pins that exist: all of port 0, the low P1_PINS of port 1
  localparam logic [63:0] VALID = {{(PORT_W-P1_PINS){1'b0}}, {P1_PINS{1'b1}}, 32'hFFFFFFFF};

  // byte lanes touched by an access of the given size at the given byte offset
  function automatic logic [31:0] lane_mask(input logic [1:0] sz, input logic [1:0] a);
    logic [3:0] be;
    logic [31:0] m;
    be = 4'hF;
    unique case (sz)
      SIZE_BYTE: be = 4'h1 << a;
      SIZE_HALF: be = a[1] ? 4'hC : 4'h3;
      default: be = 4'hF;
    endcase
    for (int k = 0; k < 4; k++) begin
      m[8*k +: 8] = {8{be[k]}};
    end
    return m;
  endfunction

  // read-modify-write merge of the written lanes into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] lm);
    return (old & ~lm) | (wd & lm);
  endfunction

  logic [15:0] wa;
  logic [31:0] lm;
  logic [31:0] wdm;
  logic port_sel;
  logic pint_wr;
  logic [11:0] loff;

  // decode shared by every write and read path; data is lane positioned
  assign wa = {bus_addr_i[15:2], 2'b00};
  assign lm = lane_mask(bus_size_i, bus_addr_i[1:0]);
  assign wdm = bus_wdata_i & lm;
  assign port_sel = bus_addr_i[15:14] == REGION_PORT;
  assign pint_wr = bus_wr_i && bus_addr_i[15:12] == BLK_PIN_IRQ;
  assign loff = wa[11:0];

  // two-stage pin synchroniser; only the second stage feeds logic
  logic [63:0] pin_m_r;
  logic [63:0] pin_s_r;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_m_r <= '0;
      pin_s_r <= '0;
    end else begin
      pin_m_r <= {port1_pin_i, port0_pin_i};
      pin_s_r <= pin_m_r & VALID; // missing port 1 pins masked only on the way into the second stage
    end
  end

  // ---------------- port block: direction and mask ----------------
  logic [63:0] dir_r;
  logic [63:0] mask_r;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dir_r <= '0;
    end else if (bus_wr_i && port_sel && wa == OFF_PORT0_DIRECTION) begin
      dir_r[31:0] <= merge(dir_r[31:0], bus_wdata_i, lm);
    end else if (bus_wr_i && port_sel && wa == OFF_PORT1_DIRECTION) begin
      dir_r[63:32] <= merge(dir_r[63:32], bus_wdata_i, lm) & VALID[63:32];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask_r <= '0;
    end else if (bus_wr_i && port_sel && wa == OFF_PORT0_ACCESS_FILTER) begin
      mask_r[31:0] <= merge(mask_r[31:0], bus_wdata_i, lm);
    end else if (bus_wr_i && port_sel && wa == OFF_PORT1_ACCESS_FILTER) begin
      mask_r[63:32] <= merge(mask_r[63:32], bus_wdata_i, lm) & VALID[63:32];
    end
  end

  // ---------------- port block: output bits ----------------
  // bit number in the 64-bit vector equals the pin number, port 1 from 32
  logic [63:0] out_r;
  logic [63:0] out_nxt;
  always_comb begin
    logic [5:0] p;
    logic [63:0] o;
    p = '0;
    o = out_r;
    if (bus_wr_i && port_sel) begin
      if (wa <= OFF_BYTE_LAST) begin
        for (int k = 0; k < 4; k++) begin
          p = wa[5:0] + 6'(k);
          if (lm[8*k] && VALID[p]) begin
            o[p] = |bus_wdata_i[8*k +: 8];
          end
        end
      end else if (wa[15:8] == OFF_WORD_PAGE) begin
        p = wa[7:2];
        if (VALID[p]) begin
          o[p] = |wdm;
        end
      end else begin
        unique case (wa)
          OFF_PORT0_LEVEL_WORD: o[31:0] = merge(o[31:0], bus_wdata_i, lm);
          OFF_PORT1_LEVEL_WORD: o[63:32] = merge(o[63:32], bus_wdata_i, lm);
          OFF_PORT0_FILTERED_WORD: o[31:0] = merge(o[31:0], bus_wdata_i, lm & ~mask_r[31:0]);
          OFF_PORT1_FILTERED_WORD: o[63:32] = merge(o[63:32], bus_wdata_i, lm & ~mask_r[63:32]);
          OFF_PORT0_OUTPUT_ASSERT: o[31:0] = o[31:0] | wdm;
          OFF_PORT1_OUTPUT_ASSERT: o[63:32] = o[63:32] | wdm;
          OFF_PORT0_OUTPUT_DEASSERT: o[31:0] = o[31:0] & ~wdm;
          OFF_PORT1_OUTPUT_DEASSERT: o[63:32] = o[63:32] & ~wdm;
          OFF_PORT0_OUTPUT_INVERT: o[31:0] = o[31:0] ^ wdm;
          OFF_PORT1_OUTPUT_INVERT: o[63:32] = o[63:32] ^ wdm;
          default: o = out_r;
        endcase
      end
    end
    out_nxt = o & VALID;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  // pin drivers come straight from the output and direction flops
  assign port0_out_o = out_r[31:0];
  assign port1_out_o = out_r[63:32];
  assign port0_oe_o = dir_r[31:0];
  assign port1_oe_o = dir_r[63:32];

  // ---------------- pin interrupts ----------------
  logic [7:0] sens_r;
  logic [7:0] rlen_r;
  logic [7:0] fpen_r;
  logic [7:0] rise_r;
  logic [7:0] fall_r;
  logic [7:0] lvl;
  logic [7:0] lvl_q_r;
  logic [7:0] rise_ev;
  logic [7:0] fall_ev;
  logic [7:0] pend;
  logic [7:0] pend_wr;

  // each interrupt watches the synchronised pin its selector names
  for (genvar n = 0; n < NUM_PIN_IRQ; n++) begin : g_src
    assign lvl[n] = pin_s_r[irq_source_selector_i[n*SEL_W +: SEL_W]];
  end

  assign rise_ev = ~sens_r & rlen_r & lvl & ~lvl_q_r;
  assign fall_ev = ~sens_r & fpen_r & ~lvl & lvl_q_r;
  // level mode: pending while pin sits at the chosen level and enabled
  assign pend = (~sens_r & (rise_r | fall_r)) |
                (sens_r & rlen_r & ~(lvl ^ fpen_r));
  assign pend_wr = (pint_wr && loff == OFF_PEND) ? wdm[7:0] : 8'h00;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lvl_q_r <= '0;
    end else begin
      lvl_q_r <= lvl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sens_r <= '0;
    end else if (pint_wr && loff == OFF_SENS) begin
      sens_r <= NUM_PIN_IRQ'(merge({24'h0, sens_r}, bus_wdata_i,
                lm));
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rlen_r <= '0;
    end else if (pint_wr && loff == OFF_RLEN) begin
      rlen_r <= NUM_PIN_IRQ'(merge({24'h0, rlen_r}, bus_wdata_i, lm));
    end else if (pint_wr && loff == OFF_RLEN_SET) begin
      rlen_r <= rlen_r | wdm[NUM_PIN_IRQ-1:0];
    end else if (pint_wr && loff == OFF_RLEN_CLR) begin
      rlen_r <= rlen_r & ~wdm[NUM_PIN_IRQ-1:0];
    end
  end

  // writing one to a pending bit in level mode flips the active level
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fpen_r <= '0;
    end else if (pint_wr && loff == OFF_FPEN) begin
      fpen_r <= NUM_PIN_IRQ'(merge({24'h0, fpen_r}, bus_wdata_i, lm));
    end else if (pint_wr && loff == OFF_FPEN_SET) begin
      fpen_r <= fpen_r | wdm[NUM_PIN_IRQ-1:0];
    end else if (pint_wr && loff == OFF_FPEN_CLR) begin
      fpen_r <= fpen_r & ~wdm[NUM_PIN_IRQ-1:0];
    end else begin
      fpen_r <= fpen_r ^ (pend_wr & sens_r);
    end
  end

  // edge records: a new edge in the clearing cycle survives the clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rise_r <= '0;
      fall_r <= '0;
    end else begin
      rise_r <= (rise_r & ~((pint_wr && loff == OFF_RISE) ? wdm[7:0] : 8'h00)
                 & ~(pend_wr & ~sens_r)) | rise_ev;
      fall_r <= (fall_r & ~((pint_wr && loff == OFF_FALL) ? wdm[7:0] : 8'h00)
                 & ~(pend_wr & ~sens_r)) | fall_ev;
    end
  end

  // interrupt request lines, registered so they come from a flop
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_irq_o <= '0;
    end else begin
      pin_irq_o <= pend;
    end
  end

  // ---------------- grouped interrupts ----------------
  logic [63:0] gpol_r [NUM_GROUPS];
  logic [63:0] gena_r [NUM_GROUPS];
  logic [2:0] gctrl_r [NUM_GROUPS];
  logic gcond_q_r [NUM_GROUPS];

  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    logic sel;
    logic [63:0] en;
    logic [63:0] hit;
    logic cond;
    logic fire;
    assign sel = bus_wr_i && bus_addr_i[15:12] == (g == 0 ? BLK_FIRST_COMBINED_IRQ_UNIT : BLK_SECOND_COMBINED_IRQ_UNIT);
    assign en = gena_r[g] & VALID;
    assign hit = ~(pin_s_r ^ gpol_r[g]) & en;
    // AND needs at least one contributor, else an empty group would fire
    assign cond = gctrl_r[g][GCTRL_COMB] ? ((|en) && &(hit | ~en)) : |hit;
    assign fire = gctrl_r[g][GCTRL_TRIG] ? cond : cond & ~gcond_q_r[g];

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        gpol_r[g] <= {GPOL_RESET, GPOL_RESET};
      end else if (sel && loff == OFF_GPOL0) begin
        gpol_r[g][31:0] <= merge(gpol_r[g][31:0], bus_wdata_i, lm);
      end else if (sel && loff == OFF_GPOL1) begin
        gpol_r[g][63:32] <= merge(gpol_r[g][63:32], bus_wdata_i, lm);
      end
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        gena_r[g] <= GENA_RESET;
      end else if (sel && loff == OFF_GENA0) begin
        gena_r[g][31:0] <= merge(gena_r[g][31:0], bus_wdata_i, lm);
      end else if (sel && loff == OFF_GENA1) begin
        gena_r[g][63:32] <= merge(gena_r[g][63:32], bus_wdata_i, lm) & VALID[63:32];
      end
    end

    // status sets on the pattern; a write of one clears unless it fires again
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        gctrl_r[g] <= '0;
        gcond_q_r[g] <= 1'b0;
      end else begin
        gcond_q_r[g] <= cond;
        if (sel && loff == OFF_GCTRL && lm[0]) begin
          gctrl_r[g][GCTRL_TRIG:GCTRL_COMB] <= bus_wdata_i[GCTRL_TRIG:GCTRL_COMB];
          gctrl_r[g][GCTRL_INT] <= fire | (gctrl_r[g][GCTRL_INT] & ~bus_wdata_i[GCTRL_INT]);
        end else begin
          gctrl_r[g][GCTRL_INT] <= fire | gctrl_r[g][GCTRL_INT];
        end
      end
    end

    assign group_irq_o[g] = gctrl_r[g][GCTRL_INT];
  end

  // ---------------- read path, data one cycle after the strobe ----------------
  logic [31:0] rd_nxt;
  always_comb begin
    logic [5:0] p;
    logic [3:0] blk;
    logic gi;
    p = '0;
    blk = bus_addr_i[15:12];
    gi = blk == BLK_SECOND_COMBINED_IRQ_UNIT;
    rd_nxt = 32'h00000000;
    if (port_sel) begin
      if (wa <= OFF_BYTE_LAST) begin
        for (int k = 0; k < 4; k++) begin
          p = wa[5:0] + 6'(k);
          rd_nxt[8*k +: 8] = {7'h00, pin_s_r[p] & VALID[p]};
        end
      end else if (wa[15:8] == OFF_WORD_PAGE) begin
        p = wa[7:2];
        rd_nxt = {32{pin_s_r[p] & VALID[p]}};
      end else begin
        unique case (wa)
          OFF_PORT0_DIRECTION: rd_nxt = dir_r[31:0];
          OFF_PORT1_DIRECTION: rd_nxt = dir_r[63:32];
          OFF_PORT0_ACCESS_FILTER: rd_nxt = mask_r[31:0];
          OFF_PORT1_ACCESS_FILTER: rd_nxt = mask_r[63:32];
          OFF_PORT0_LEVEL_WORD: rd_nxt = pin_s_r[31:0];
          OFF_PORT1_LEVEL_WORD: rd_nxt = pin_s_r[63:32];
          OFF_PORT0_FILTERED_WORD: rd_nxt = pin_s_r[31:0] & ~mask_r[31:0];
          OFF_PORT1_FILTERED_WORD: rd_nxt = pin_s_r[63:32] & ~mask_r[63:32];
          OFF_PORT0_OUTPUT_ASSERT: rd_nxt = out_r[31:0];
          OFF_PORT1_OUTPUT_ASSERT: rd_nxt = out_r[63:32];
          default: rd_nxt = 32'h00000000;
        endcase
      end
    end else if (blk == BLK_PIN_IRQ) begin
      unique case (loff)
        OFF_SENS: rd_nxt = {24'h000000, sens_r};
        OFF_RLEN: rd_nxt = {24'h000000, rlen_r};
        OFF_FPEN: rd_nxt = {24'h000000, fpen_r};
        OFF_RISE: rd_nxt = {24'h000000, rise_r};
        OFF_FALL: rd_nxt = {24'h000000, fall_r};
        OFF_PEND: rd_nxt = {24'h000000, pend};
        default: rd_nxt = 32'h00000000;
      endcase
    end else if (blk == BLK_FIRST_COMBINED_IRQ_UNIT || gi) begin
      unique case (loff)
        OFF_GCTRL: rd_nxt = {29'h00000000, gctrl_r[gi]};
        OFF_GPOL0: rd_nxt = gpol_r[gi][31:0];
        OFF_GPOL1: rd_nxt = gpol_r[gi][63:32];
        OFF_GENA0: rd_nxt = gena_r[gi][31:0];
        OFF_GENA1: rd_nxt = gena_r[gi][63:32];
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_rdata_o <= '0;
    end else begin
      bus_rdata_o <= bus_rd_i ? rd_nxt : 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// File: test_gpio_port_pin_group_irq.sv
// self-checking bench for the pin unit: registers, outputs, pin reads, interrupts
// assumes gpg_board closes the pin loop; one gap cycle between bus strobes
`timescale 1ns/1ns
`default_nettype none

module test_gpio_port_pin_group_irq;
  import gpg_pkg::*;
  logic clk_i, sys_rst_i, bus_wr, bus_rd;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, o0, oe0, o1, oe1, ext0, ext1, port0_level_word, port1_level_word, v, d, m, e0, e1;
  logic [1:0] size;
  logic [47:0] sel;
  logic [7:0] pirq;
  logic [1:0] girq;
  int seed, cyc, fails, tests_run;
  logic [15:0] ra [14] = '{16'h2000, 16'h2004, 16'h2080, 16'h2200, 16'h2280, 16'h3000,
    16'h4000, 16'h4004, 16'h4024, 16'h5000, 16'h5020, 16'h6024, 16'h5040, 16'h6044};
  logic [31:0] rv [14] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 32'hFFFFFFFF, 32'hFFFFFFFF, 0, 0};
  logic [15:0] oa [3] = '{16'h2200, 16'h2280, 16'h2300};

  gpg_top #(.P1_PINS(10)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_addr_i(addr),
    .bus_wdata_i(wdata), .bus_size_i(size), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd),
    .bus_rdata_o(rdata), .port0_pin_i(port0_level_word), .port1_pin_i(port1_level_word), .port0_out_o(o0),
    .port0_oe_o(oe0), .port1_out_o(o1), .port1_oe_o(oe1), .irq_source_selector_i(sel),
    .pin_irq_o(pirq), .group_irq_o(girq));
  gpg_board board (.out0_i(o0), .oe0_i(oe0), .out1_i(o1), .oe1_i(oe1), .ext0_i(ext0),
    .ext1_i(ext1), .port0_level_word_o(port0_level_word), .port1_level_word_o(port1_level_word));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // expected port output after a set, clear or toggle word
  function automatic logic [31:0] nxt(input logic [31:0] o, input logic [31:0] x, input int k);
    return (k == 0) ? (o | x) : (k == 1) ? (o & ~x) : (o ^ x);
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // one strobe cycle then one idle cycle, so strobes never collide in a time step
  task automatic wr(input logic [15:0] a, input logic [31:0] x, input logic [1:0] s);
    addr <= a;
    wdata <= x;
    size <= s;
    bus_wr <= 1'b1;
    @(posedge clk_i);
    bus_wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] x);
    addr <= a;
    size <= SIZE_WORD;
    bus_rd <= 1'b1;
    @(posedge clk_i);
    bus_rd <= 1'b0;
    #1 x = rdata;
    @(posedge clk_i);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    seed = 97;
    {bus_wr, bus_rd, addr, wdata, size, ext0, ext1, e0, e1} = '0;
    sel = {42'h0, 6'h05};
    sys_rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk("reset value", v, rv[i]);
    end
    wr(16'h2000, 32'hFFFFFFFF, SIZE_WORD);
    wr(16'h2004, 32'hFFFFFFFF, SIZE_WORD);
    rd(16'h2004, v);
    chk("port1_direction", v, 32'h000003FF);
    // random set, clear and toggle words on port 0
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      wr(oa[i % 3], d, SIZE_WORD);
      e0 = nxt(e0, d, i % 3);
      rd(16'h2200, v);
      chk("out0", v, e0);
    end
    d = $random(seed);
    wr(16'h2204, d, SIZE_WORD);
    e1 = d & 32'h000003FF;
    rd(16'h2204, v);
    chk("out1", v, e1);
    // masked access leaves masked bits alone and reads them as zero
    m = $random(seed);
    d = $random(seed);
    wr(16'h2080, m, SIZE_WORD);
    wr(16'h2180, d, SIZE_WORD);
    e0 = (e0 & m) | (d & ~m);
    repeat (2) @(posedge clk_i);
    rd(16'h2180, v);
    chk("port0_filtered_word", v, e0 & ~m);
    rd(16'h2100, v);
    chk("port0_level_word", v, e0);
    wr(16'h2080, 32'h0, SIZE_WORD);
    // byte and halfword pin access, then word pins
    wr(16'h0005, 32'h00008000, SIZE_BYTE);
    wr(16'h0006, 32'h01000000, SIZE_HALF);
    e0[7:5] = 3'b101;
    wr(16'h0021, 32'h00000100, SIZE_BYTE);
    e1[1] = 1'b1;
    repeat (2) @(posedge clk_i);
    rd(16'h0004, v);
    chk("bytes", v, {7'h0, e0[7], 7'h0, e0[6], 7'h0, e0[5], 7'h0, e0[4]});
    rd(16'h2204, v);
    chk("byte33", v, e1);
    wr(16'h1008, 32'h0, SIZE_WORD);
    wr(16'h1088, 32'h00000005, SIZE_WORD);
    e0[2] = 1'b0;
    e1[2] = 1'b1;
    repeat (2) @(posedge clk_i);
    rd(16'h1008, v);
    chk("word2", v, 32'h0);
    rd(16'h1088, v);
    chk("word34", v, 32'hFFFFFFFF);
    rd(16'h2204, v);
    chk("out1w", v, e1);
    // inputs sensed from the board
    wr(16'h2000, 32'h0, SIZE_WORD);
    ext0 <= $random(seed) & 32'hFFFFFFDF;
    repeat (3) @(posedge clk_i);
    rd(16'h2100, v);
    chk("pin in", v, ext0);
    // edge interrupt on pin 5 through selector 0
    wr(16'h4008, 32'h1, SIZE_WORD);
    rd(16'h4004, v);
    chk("rlen set", v, 32'h1);
    ext0[5] <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("irq rise", {24'h0, pirq}, 32'h1);
    rd(16'h4024, v);
    chk("pending", v, 32'h1);
    wr(16'h4024, 32'h1, SIZE_WORD);
    ext0[5] <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("fall ignored", {24'h0, pirq}, 32'h0);
    wr(16'h400C, 32'h1, SIZE_WORD);
    rd(16'h4004, v);
    chk("rlen clr", v, 32'h0);
    // level interrupt, low active then high active
    wr(16'h4000, 32'h1, SIZE_WORD);
    wr(16'h4008, 32'h1, SIZE_WORD);
    repeat (4) @(posedge clk_i);
    chk("level low", {24'h0, pirq}, 32'h1);
    wr(16'h4014, 32'h1, SIZE_WORD);
    repeat (4) @(posedge clk_i);
    chk("level high", {24'h0, pirq}, 32'h0);
    // falling edge only: back to edge mode, rising enable off, falling enable still set
    wr(16'h4000, 32'h0, SIZE_WORD);
    wr(16'h400C, 32'h1, SIZE_WORD);
    ext0[5] <= 1'b1;
    repeat (4) @(posedge clk_i);
    ext0[5] <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("irq fall", {24'h0, pirq}, 32'h1);
    rd(16'h4020, v);
    chk("fall rec", v, 32'h1);
    wr(16'h4020, 32'h1, SIZE_WORD);
    repeat (2) @(posedge clk_i);
    chk("fall clr", {24'h0, pirq}, 32'h0);
    // group 0 watches port 1 pin 2, default high polarity
    wr(16'h2004, 32'h0, SIZE_WORD);
    wr(16'h5044, 32'h4, SIZE_WORD);
    ext1 <= 32'h4;
    repeat (6) @(posedge clk_i);
    chk("group", {30'h0, girq}, 32'h1);
    ext1 <= 32'h0;
    wr(16'h5000, 32'h1, SIZE_WORD);
    repeat (3) @(posedge clk_i);
    chk("group clr", {30'h0, girq}, 32'h0);
    // group 1: AND of port 1 pins 2 and 3, level triggered; group 0 sees pin 2 rise again
    wr(16'h6044, 32'hC, SIZE_WORD);
    wr(16'h6000, 32'h6, SIZE_WORD);
    ext1 <= 32'h4;
    repeat (6) @(posedge clk_i);
    chk("group or", {30'h0, girq}, 32'h1);
    ext1 <= 32'hC;
    repeat (6) @(posedge clk_i);
    chk("group and", {30'h0, girq}, 32'h3);
    give_verdict();
  end
endmodule

`default_nettype wire
